// ==== dv/ecp_epp_parallel_port_test.sv ====
`timescale 1ns/1ps
`include "epp_cfg.svh"
module ecp_epp_parallel_port_test;
	logic        clk = 0, rst_n = 0, hsel = 0, hwr = 0, rd_dp = 0, hang = 0;
	logic        busy = 0, ack_n = 1, perr = 0, sel = 0, flt_n = 1, mbusy = 0;
	logic        ext_en = 0, rdy, oe, wsn, dsn, asn, stn, afn, sln, inn, wt_n;
	logic [1:0]  htr = 0;
	logic [31:0] hadr = 0, hwd = 0, hrd;
	logic [7:0]  pd_o, pd_m, ext_v = 0, d;
	logic [7:0]  exp_q[$];
	logic        hresp, irq;
	logic [7:0]  irqs = 0;
	int          miscompares = 0, comparisons = 0, cyc = 0, t0, n, stbs = 0;
	wire  [7:0]  pd = oe ? pd_o : pd_m;
	always #5 clk = ~clk;
	epp_port u_dut (.sys_clk_in(clk), .resetn_in(rst_n), .hsel_in(hsel),
		.haddr_in(hadr), .htrans_in(htr), .hwrite_in(hwr), .hsize_in(3'h2),
		.hwdata_in(hwd), .hready_in(rdy), .hrdata_out(hrd),
		.hreadyout_out(rdy), .hresp_out(hresp), .port_data_lines_in(pd),
		.port_data_lines_out(pd_o), .port_data_lines_oe_out(oe),
		.busy_in(busy), .ack_n_in(ack_n), .paper_error_in(perr),
		.printer_select_in(sel), .fault_n_in(flt_n),
		.peripheral_wait_n_in(wt_n), .write_select_n_out(wsn),
		.data_strobe_n_out(dsn), .addr_strobe_n_out(asn),
		.strobe_n_out(stn), .auto_feed_n_out(afn), .select_in_n_out(sln),
		.peripheral_init_n_out(inn), .ack_irq_out(irq));
	epp_periph_model u_per (.clk_in(clk), .wsel_n_in(wsn), .dstb_n_in(dsn),
		.astb_n_in(asn), .init_n_in(inn), .pd_in(pd), .hang_in(hang),
		.busy_in(mbusy), .ext_en_in(ext_en), .ext_in(ext_v),
		.wait_n_out(wt_n), .pd_out(pd_m));
	task automatic chk(input logic [7:0] got, input logic [7:0] ex);
		comparisons++;
		if (got !== ex) begin
			miscompares++;
			$display("[FAIL] %0t got %h want %h", $time, got, ex);
		end
	endtask : chk
	task automatic stop_test();
		$display("mismatches %0d of %0d", miscompares, comparisons);
		if (miscompares == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : stop_test
	// read value is queued; the watcher compares when hready returns
	task automatic ahb(input logic w, input logic [11:0] i, input logic [7:0] v);
		hsel <= 1'b1;
		hadr <= {18'h0, i, 2'b00};
		htr <= 2'b10;
		hwr <= w;
		do @(posedge clk); while (rdy !== 1'b1);
		hsel <= 1'b0;
		htr <= 2'b00;
		// reads put the inverse on hwdata so a stale capture cannot pass
		hwd <= {24'h0, w ? v : ~v};
		rd_dp <= !w;
		if (!w)
			exp_q.push_back(v);
		do @(posedge clk); while (rdy !== 1'b1);
		rd_dp <= 1'b0;
	endtask : ahb
	function automatic logic [7:0] st(input logic b0);
		return {~busy, ack_n, perr, sel, flt_n, 2'b11, b0};
	endfunction : st
	always @(posedge clk)
		if (rd_dp && rdy === 1'b1) begin
			chk(hrd[7:0], exp_q.pop_front());
			chk({7'h0, hresp}, 8'h00);
		end
	// strobe-low cycles carrying the expected byte, and irq pulses
	always @(posedge clk) begin
		if (stn === 1'b0 && pd_o === d)
			stbs <= stbs + 1;
		if (irq === 1'b1)
			irqs <= irqs + 8'h01;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			miscompares++;
			stop_test();
		end
	end
	initial begin
		void'($urandom(39));
		d = $urandom;
		{busy, ack_n, perr, sel, flt_n} <= d[4:0];
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		ahb(0, `EPP_IDX_DSR, st(1'b1));
		ahb(1, `EPP_IDX_DCR, 8'h35);
		ahb(0, `EPP_IDX_DCR, 8'hf5);
		chk({4'h0, sln, inn, afn, stn}, 8'h0e);
		ack_n <= 1'b0;
		repeat (4) @(posedge clk);
		ack_n <= 1'b1;
		repeat (6) @(posedge clk);
		chk(irqs, 8'h01);
		d = $urandom;
		ahb(1, `EPP_IDX_DATA, d);
		repeat (3) @(posedge clk);
		ahb(0, `EPP_IDX_DATA, d);
		chk({7'h0, oe}, 8'h01);
		ext_v <= $urandom;
		ext_en <= 1'b1;
		ahb(1, `EPP_IDX_ECR, 8'h20);
		repeat (3) @(posedge clk);
		ahb(0, `EPP_IDX_DATA, ext_v);
		chk({7'h0, oe}, 8'h00);
		ext_en <= 1'b0;
		ahb(1, `EPP_IDX_OPT, 8'h01);
		ahb(1, `EPP_IDX_ECR, 8'h80);
		ahb(0, `EPP_IDX_ECR, 8'h81);
		chk({7'h0, oe}, 8'h00);
		d = $urandom;
		ahb(1, `EPP_IDX_EPP_ADDR, {6'h0, d[7:6]});
		ahb(1, `EPP_IDX_EPP_DATA0, d);
		ahb(0, `EPP_IDX_EPP_ADDR, {6'h0, d[7:6]});
		ahb(0, `EPP_IDX_EPP_DATA0, d);
		hang <= 1'b1;
		t0 = cyc;
		ahb(0, `EPP_IDX_EPP_DATA0, 8'hff);
		chk({7'h0, (cyc - t0) >= 1000}, 8'h01);
		hang <= 1'b0;
		ahb(0, `EPP_IDX_DSR, st(1'b1));
		ahb(1, `EPP_IDX_DSR, 8'h00);
		ahb(0, `EPP_IDX_DSR, st(1'b1));
		ahb(1, `EPP_IDX_DSR, 8'h01);
		ahb(0, `EPP_IDX_DSR, st(1'b0));
		ahb(1, `EPP_IDX_OPT, 8'h03);
		mbusy <= 1'b1;
		fork
			ahb(1, `EPP_IDX_EPP_DATA0, ~d);
			begin
				repeat (40) @(posedge clk);
				chk({7'h0, dsn}, 8'h01);
				mbusy <= 1'b0;
			end
		join
		ahb(0, `EPP_IDX_EPP_DATA0, ~d);
		ahb(1, `EPP_IDX_ECR, 8'hc0);
		ahb(1, `EPP_IDX_FIFO, d);
		ahb(0, `EPP_IDX_ECR, 8'hc0);
		ahb(1, `EPP_IDX_ECR, 8'h00);
		ahb(1, `EPP_IDX_ECR, 8'hc0);
		ahb(0, `EPP_IDX_ECR, 8'hc1);
		ahb(0, 12'h010, 8'h00);
		ahb(1, `EPP_IDX_ECR, 8'he0);
		ahb(0, `EPP_IDX_FIFO, `EPP_CFGA_VAL);
		// run count 2 then one data byte: three strobes, busy gates each
		busy <= 1'b1;
		ahb(1, `EPP_IDX_DCR, 8'h04);
		ahb(1, `EPP_IDX_ECR, 8'h60);
		ahb(1, `EPP_IDX_DATA, 8'h02);
		ahb(1, `EPP_IDX_FIFO, d);
		n = stbs;
		repeat (20) @(posedge clk);
		chk(8'(stbs - n), 8'h00);
		busy <= 1'b0;
		repeat (340) @(posedge clk);
		chk(8'(stbs - n), 8'h96);
		repeat (2) @(posedge clk);
		stop_test();
	end
endmodule : ecp_epp_parallel_port_test

// ==== dv/epp_periph_model.sv ====
`timescale 1ns/1ps
module epp_periph_model (
	input  wire logic       clk_in,     // bench clock
	input  wire logic       wsel_n_in,  // low = host writes
	input  wire logic       dstb_n_in,  // data strobe
	input  wire logic       astb_n_in,  // address strobe
	input  wire logic       init_n_in,  // reset request
	input  wire logic [7:0] pd_in,      // resolved lines
	input  wire logic       hang_in,    // never finish
	input  wire logic       busy_in,    // hold wait high
	input  wire logic       ext_en_in,  // drive ext_in
	input  wire logic [7:0] ext_in,     // forced value
	output logic            wait_n_out, // low = ready
	output logic      [7:0] pd_out      // model value
);
	logic [1:0] addr_q;
	logic [7:0] mem_q [4];
	logic [7:0] last_q;
	logic [2:0] dly_q;
	wire        stb = !dstb_n_in || !astb_n_in;
	wire  [7:0] rd_v = astb_n_in ? mem_q[addr_q] : {6'h00, addr_q};
	// released lines flip every cycle so a stale read fails
	assign pd_out = ext_en_in ? ext_in : (stb && wsel_n_in) ? rd_v : ~last_q;
	assign wait_n_out = busy_in || (stb && dly_q == 3'h4);
	always @(posedge clk_in) begin
		last_q <= pd_in;
		if (!stb || hang_in)
			dly_q <= 3'h0;
		else if (dly_q != 3'h4)
			dly_q <= dly_q + 3'h1;
		if (stb && !wsel_n_in && dly_q == 3'h3 && astb_n_in)
			mem_q[addr_q] <= pd_in;
		if (stb && !wsel_n_in && dly_q == 3'h3 && !astb_n_in)
			addr_q <= pd_in[1:0];
		if (!init_n_in) begin
			addr_q <= 2'h0;
			mem_q <= '{default: 8'h00};
		end
	end
endmodule : epp_periph_model

// ==== hdl/epp_cfg.svh ====
`ifndef EPP_CFG_SVH
`define EPP_CFG_SVH

// ----------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define EPP_IDX_DATA      12'h000
`define EPP_IDX_DSR       12'h001
`define EPP_IDX_DCR       12'h002
`define EPP_IDX_EPP_ADDR  12'h003
`define EPP_IDX_EPP_DATA0 12'h004
`define EPP_IDX_EPP_DATA3 12'h007
`define EPP_IDX_FIFO      12'h400
`define EPP_IDX_CFGB      12'h401
`define EPP_IDX_ECR       12'h402
`define EPP_IDX_OPT       12'h403

// ----------------------------------------------------------------
// field positions and fixed values
// ----------------------------------------------------------------
`define EPP_DCR_DIR       5
`define EPP_DCR_IRQEN     4
`define EPP_DCR_SELECT_IN_OUT      3
`define EPP_DCR_INIT      2
`define EPP_DCR_AFD       1
`define EPP_DCR_STB       0
`define EPP_OPT_EN        0
`define EPP_OPT_V19       1
`define EPP_CFGA_VAL      8'h10
`define EPP_CFGB_RST      6'h07
`define EPP_FIFO_DEPTH    16
`define EPP_FIFO_AW       4

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define EPP_CLK_NS        10
`define EPP_TMO_NS        10000
`define EPP_TMO_CYC       ((`EPP_TMO_NS + `EPP_CLK_NS - 1) / `EPP_CLK_NS)
`define EPP_STB_NS        500
`define EPP_STB_CYC       ((`EPP_STB_NS + `EPP_CLK_NS - 1) / `EPP_CLK_NS)

`endif

// ==== hdl/epp_fifo.sv ====
`timescale 1ns/1ps
`include "epp_cfg.svh"
module epp_fifo (
	input  wire logic       sys_clk_in, // system clock
	input  wire logic       resetn_in,  // sync reset, active low
	input  wire logic       clear_in,   // empties the fifo
	input  wire logic       push_in,    // write one entry
	input  wire logic [8:0] push_data_in, // tag bit 8, byte 7:0
	input  wire logic       pop_in,     // drop the head entry
	output logic      [8:0] head_out,   // entry at the head
	output logic            empty_out,  // no entry held
	output logic            full_out    // no room left
);
	typedef struct packed {
		logic [`EPP_FIFO_DEPTH-1:0][8:0] mem;
		logic [`EPP_FIFO_AW-1:0]         wp;
		logic [`EPP_FIFO_AW-1:0]         rp;
		logic [`EPP_FIFO_AW:0]           cnt;
	} epp_fifo_st_t;

	epp_fifo_st_t st_q;
	epp_fifo_st_t st_d;
	logic         do_push;
	logic         do_pop;

	// push on full and pop on empty are dropped silently
	always_comb begin
		st_d    = st_q;
		do_push = push_in && !full_out;
		do_pop  = pop_in && !empty_out;
		if (do_push) begin
			st_d.mem[st_q.wp] = push_data_in;
			st_d.wp           = st_q.wp + 1'b1;
		end
		if (do_pop) begin
			st_d.rp = st_q.rp + 1'b1;
		end
		if (do_push && !do_pop) begin
			st_d.cnt = st_q.cnt + 1'b1;
		end else if (do_pop && !do_push) begin
			st_d.cnt = st_q.cnt - 1'b1;
		end
		if (clear_in) begin
			st_d.wp  = '0;
			st_d.rp  = '0;
			st_d.cnt = '0;
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (!resetn_in) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign head_out  = st_q.mem[st_q.rp];
	assign empty_out = (st_q.cnt == '0);
	assign full_out  = (st_q.cnt == (`EPP_FIFO_AW+1)'(`EPP_FIFO_DEPTH));
endmodule : epp_fifo

// ==== hdl/epp_pkg.sv ====
package epp_pkg;
	typedef enum logic [2:0] {
		EPP_MODE_STD   = 3'b000,
		EPP_MODE_BIDIR = 3'b001,
		EPP_MODE_FIFO  = 3'b010,
		EPP_MODE_ECP   = 3'b011,
		EPP_MODE_EPP   = 3'b100,
		EPP_MODE_RSVD  = 3'b101,
		EPP_MODE_TEST  = 3'b110,
		EPP_MODE_CFG   = 3'b111
	} epp_mode_t;

	typedef enum logic [1:0] {
		EPP_CYC_IDLE   = 2'b00,
		EPP_CYC_WAITGO = 2'b01,
		EPP_CYC_STROBE = 2'b10,
		EPP_CYC_DONE   = 2'b11
	} epp_cyc_t;

	typedef enum logic [1:0] {
		EPP_TX_IDLE = 2'b00,
		EPP_TX_WAIT = 2'b01,
		EPP_TX_STB  = 2'b10,
		EPP_TX_HOLD = 2'b11
	} epp_tx_t;

	typedef struct packed {
		logic             hready;
		logic             hresp;
		logic [31:0]      hrdata;
		logic             dp;
		logic             dp_wr;
		logic [11:0]      dp_idx;
		logic [7:0]       data;
		logic [5:0]       dcr;
		epp_mode_t        mode;
		logic [2:0]       ecr_ctl;
		logic [5:0]       cfgb;
		logic [1:0]       opt;
		logic             tmo;
		epp_cyc_t         cyc;
		logic             cyc_wr;
		logic             cyc_addr;
		logic             seen_low;
		logic [9:0]       wdog;
		logic [7:0]       eppbuf;
		epp_tx_t          tx;
		logic [7:0]       txbyte;
		logic [6:0]       rle;
		logic [5:0]       txcnt;
		logic             ack_d;
		logic             irq;
		logic [7:0]       pd_out;
		logic             pd_oe;
		logic             wsel_n;
		logic             dstb_n;
		logic             astb_n;
		logic             stb_n;
		logic             afd_n;
		logic             select_in_out_n;
		logic             init_n;
	} epp_state_t;
endpackage : epp_pkg

// ==== hdl/epp_port.sv ====
`timescale 1ns/1ps
`include "epp_cfg.svh"
module epp_port (
	input  wire logic        sys_clk_in,        // 100 MHz clock
	input  wire logic        resetn_in,         // sync reset, active low
	input  wire logic        hsel_in,           // ahb slave select
	input  wire logic [31:0] haddr_in,          // ahb address
	input  wire logic [1:0]  htrans_in,         // ahb transfer type
	input  wire logic        hwrite_in,         // ahb write
	input  wire logic [2:0]  hsize_in,          // ahb size, word only
	input  wire logic [31:0] hwdata_in,         // ahb write data
	input  wire logic        hready_in,         // ahb bus ready
	output logic      [31:0] hrdata_out,        // ahb read data
	output logic             hreadyout_out,     // ahb slave ready
	output logic             hresp_out,         // ahb response, okay
	input  wire logic [7:0]  port_data_lines_in, // data pins, input
	output logic      [7:0]  port_data_lines_out, // data pins, output
	output logic             port_data_lines_oe_out, // data pins drive
	input  wire logic        busy_in,           // printer busy
	input  wire logic        ack_n_in,          // acknowledge, low
	input  wire logic        paper_error_in,    // paper error
	input  wire logic        printer_select_in, // printer selected
	input  wire logic        fault_n_in,        // fault, low
	input  wire logic        peripheral_wait_n_in, // epp wait, low
	output logic             write_select_n_out, // epp write select
	output logic             data_strobe_n_out, // epp data strobe
	output logic             addr_strobe_n_out, // epp address strobe
	output logic             strobe_n_out,      // printer strobe
	output logic             auto_feed_n_out,   // printer auto feed
	output logic             select_in_n_out,   // printer select-in
	output logic             peripheral_init_n_out, // init, low
	output logic             ack_irq_out        // ack interrupt pulse
);
	import epp_pkg::*;

	// ----------------------------------------------------------------
	// pin synchronisers and fifo
	// ----------------------------------------------------------------
	logic [13:0] syn;
	logic [7:0]  pd_s;
	logic        busy_s;
	logic        ack_s;
	logic        perr_s;
	logic        sel_s;
	logic        flt_s;
	logic        wait_s;

	epp_sync2 #(.W(14)) u_sync (
		.sys_clk_in (sys_clk_in),
		.resetn_in  (resetn_in),
		.async_in   ({peripheral_wait_n_in, fault_n_in, printer_select_in,
		              paper_error_in, ack_n_in, busy_in,
		              port_data_lines_in}),
		.sync_out   (syn)
	);
	assign {wait_s, flt_s, sel_s, perr_s, ack_s, busy_s, pd_s} = syn;

	epp_state_t st_q;
	epp_state_t s;
	logic       f_clear;
	logic       f_push;
	logic [8:0] f_pdata;
	logic       f_pop;
	logic [8:0] f_head;
	logic       f_empty;
	logic       f_full;
	logic       tmo_set;
	logic       tmo_clr;
	logic       epp_on;
	logic       acc_epp;
	logic [31:0] rd;

	// one shared fifo serves every fifo mode; only host writes fill it, the port never does
	epp_fifo u_fifo (
		.sys_clk_in   (sys_clk_in),
		.resetn_in    (resetn_in),
		.clear_in     (f_clear),
		.push_in      (f_push),
		.push_data_in (f_pdata),
		.pop_in       (f_pop),
		.head_out     (f_head),
		.empty_out    (f_empty),
		.full_out     (f_full)
	);

	assign f_clear = (st_q.mode == EPP_MODE_STD);
	assign epp_on  = (st_q.mode == EPP_MODE_EPP) && st_q.opt[`EPP_OPT_EN];
	assign acc_epp = epp_on && (st_q.dp_idx >= `EPP_IDX_EPP_ADDR)
		&& (st_q.dp_idx <= `EPP_IDX_EPP_DATA3);

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		s       = st_q;
		f_push  = 1'b0;
		f_pdata = '0;
		f_pop   = 1'b0;
		tmo_set = 1'b0;
		tmo_clr = 1'b0;
		rd      = '0;
		s.irq   = 1'b0;
		s.ack_d = ack_s;
		if (ack_s && !st_q.ack_d && st_q.dcr[`EPP_DCR_IRQEN]) begin
			s.irq = 1'b1;
		end

		// address phase; every data phase gets at least one wait state
		if (hsel_in && hready_in && htrans_in[1]) begin
			s.dp     = 1'b1;
			s.dp_wr  = hwrite_in;
			s.dp_idx = haddr_in[13:2];
			s.hready = 1'b0;
		end

		if (st_q.dp && !st_q.hready && acc_epp) begin
			if (st_q.cyc == EPP_CYC_IDLE) begin
				s.cyc_wr   = st_q.dp_wr;
				s.cyc_addr = (st_q.dp_idx == `EPP_IDX_EPP_ADDR);
				s.eppbuf   = hwdata_in[7:0];
				s.wdog     = '0;
				s.seen_low = 1'b0;
				// newer variant checks wait first, older one goes at once
				s.cyc = st_q.opt[`EPP_OPT_V19] ? EPP_CYC_WAITGO
					: EPP_CYC_STROBE;
			end
		end else if (st_q.dp && !st_q.hready) begin
			s.hready = 1'b1;
			s.dp     = 1'b0;
			if (st_q.dp_wr) begin
				if (st_q.dp_idx == `EPP_IDX_DATA) begin
					if (st_q.mode == EPP_MODE_ECP) begin
						f_push  = 1'b1;
						f_pdata = {1'b1, hwdata_in[7:0]};
					end else begin
						s.data = hwdata_in[7:0];
					end
				end else if (st_q.dp_idx == `EPP_IDX_DSR) begin
					tmo_clr = hwdata_in[0];
				end else if (st_q.dp_idx == `EPP_IDX_DCR) begin
					s.dcr = hwdata_in[5:0];
				end else if (st_q.dp_idx == `EPP_IDX_FIFO) begin
					if (st_q.mode == EPP_MODE_FIFO
						|| st_q.mode == EPP_MODE_ECP
						|| st_q.mode == EPP_MODE_TEST) begin
						f_push  = 1'b1;
						f_pdata = {1'b0, hwdata_in[7:0]};
					end
				end else if (st_q.dp_idx == `EPP_IDX_CFGB) begin
					if (st_q.mode == EPP_MODE_CFG) begin
						s.cfgb = hwdata_in[5:0];
					end
				end else if (st_q.dp_idx == `EPP_IDX_ECR) begin
					s.mode    = epp_mode_t'(hwdata_in[7:5]);
					s.ecr_ctl = hwdata_in[4:2];
				end else if (st_q.dp_idx == `EPP_IDX_OPT) begin
					s.opt = hwdata_in[1:0];
				end
			end else begin
				if (st_q.dp_idx == `EPP_IDX_DATA) begin
					rd[7:0] = pd_s;
				end else if (st_q.dp_idx == `EPP_IDX_DSR) begin
					rd[7:0] = {!busy_s, ack_s, perr_s, sel_s, flt_s, 2'b11,
						epp_on ? st_q.tmo : 1'b1};
				end else if (st_q.dp_idx == `EPP_IDX_DCR) begin
					rd[7:0] = {2'b11, st_q.dcr};
				end else if (st_q.dp_idx == `EPP_IDX_FIFO) begin
					if (st_q.mode == EPP_MODE_CFG) begin
						rd[7:0] = `EPP_CFGA_VAL;
					end else if (st_q.mode == EPP_MODE_TEST
						|| (st_q.mode == EPP_MODE_ECP
						&& st_q.dcr[`EPP_DCR_DIR])) begin
						rd[7:0] = f_head[7:0];
						f_pop   = 1'b1;
					end
				end else if (st_q.dp_idx == `EPP_IDX_CFGB) begin
					rd[7:0] = {1'b0, st_q.irq, st_q.cfgb};
				end else if (st_q.dp_idx == `EPP_IDX_ECR) begin
					rd[7:0] = {st_q.mode, st_q.ecr_ctl, f_full, f_empty};
				end else if (st_q.dp_idx == `EPP_IDX_OPT) begin
					rd[1:0] = st_q.opt;
				end
			end
			s.hrdata = rd;
		end

		// ----------------------------------------------------------------
		// epp cycle engine
		// ----------------------------------------------------------------
		case (st_q.cyc)
			EPP_CYC_WAITGO: begin
				s.wdog = st_q.wdog + 1'b1;
				if (!wait_s) begin
					s.seen_low = 1'b1;
					s.cyc      = EPP_CYC_STROBE;
				end
			end
			EPP_CYC_STROBE: begin
				s.wdog = st_q.wdog + 1'b1;
				if (!wait_s) begin
					s.seen_low = 1'b1;
				end
				// wait released after being low marks completion
				if (wait_s && st_q.seen_low) begin
					s.cyc = EPP_CYC_DONE;
					if (!st_q.cyc_wr) begin
						s.eppbuf = pd_s;
					end
				end
			end
			EPP_CYC_DONE: begin
				s.cyc    = EPP_CYC_IDLE;
				s.hready = 1'b1;
				s.dp     = 1'b0;
				s.hrdata = {24'h000000, st_q.eppbuf};
			end
			default: begin
			end
		endcase
		if ((st_q.cyc == EPP_CYC_WAITGO || st_q.cyc == EPP_CYC_STROBE)
			&& st_q.wdog == 10'(`EPP_TMO_CYC)) begin
			tmo_set  = 1'b1;
			s.cyc    = EPP_CYC_DONE;
			s.eppbuf = 8'hff;
			s.wdog   = st_q.wdog;
		end
		// a time-out in the clearing cycle still lands
		if (tmo_clr) begin
			s.tmo = 1'b0;
		end
		if (tmo_set) begin
			s.tmo = 1'b1;
		end

		// ----------------------------------------------------------------
		// forward fifo drain with run-length expansion
		// ----------------------------------------------------------------
		case (st_q.tx)
			EPP_TX_IDLE: begin
				if (!f_empty && !st_q.dcr[`EPP_DCR_DIR]
					&& (st_q.mode == EPP_MODE_FIFO
					|| st_q.mode == EPP_MODE_ECP)) begin
					f_pop = 1'b1;
					if (f_head[8] && !f_head[7]) begin
						s.rle = f_head[6:0];
					end else begin
						s.txbyte = f_head[7:0];
						s.tx     = EPP_TX_WAIT;
						if (f_head[8]) begin
							s.rle = '0;
						end
					end
				end
			end
			EPP_TX_WAIT: begin
				s.txcnt = '0;
				if (!busy_s) begin
					s.tx = EPP_TX_STB;
				end
			end
			EPP_TX_STB: begin
				s.txcnt = st_q.txcnt + 1'b1;
				if (st_q.txcnt == 6'(`EPP_STB_CYC - 1)) begin
					s.txcnt = '0;
					s.tx    = EPP_TX_HOLD;
				end
			end
			EPP_TX_HOLD: begin
				s.txcnt = st_q.txcnt + 1'b1;
				if (st_q.txcnt == 6'(`EPP_STB_CYC - 1)) begin
					if (st_q.rle != '0) begin
						s.rle = st_q.rle - 1'b1;
						s.tx  = EPP_TX_WAIT;
					end else begin
						s.tx = EPP_TX_IDLE;
					end
				end
			end
			default: begin
			end
		endcase
		if (st_q.mode == EPP_MODE_STD) begin
			s.tx  = EPP_TX_IDLE;
			s.rle = '0;
		end

		// ----------------------------------------------------------------
		// pins, registered
		// ----------------------------------------------------------------
		if (s.cyc != EPP_CYC_IDLE) begin
			s.pd_oe  = s.cyc_wr;
			s.pd_out = s.eppbuf;
		end else begin
			s.pd_oe = (s.mode == EPP_MODE_STD || s.mode == EPP_MODE_FIFO)
				|| !s.dcr[`EPP_DCR_DIR];
			s.pd_out = (s.tx != EPP_TX_IDLE) ? s.txbyte : s.data;
		end
		s.wsel_n = !(s.cyc != EPP_CYC_IDLE && s.cyc_wr);
		s.dstb_n = !(s.cyc == EPP_CYC_STROBE && !s.cyc_addr);
		s.astb_n = !(s.cyc == EPP_CYC_STROBE && s.cyc_addr);
		s.stb_n  = (s.tx == EPP_TX_STB) ? 1'b0 : !s.dcr[`EPP_DCR_STB];
		s.afd_n  = !s.dcr[`EPP_DCR_AFD];
		s.select_in_out_n = !s.dcr[`EPP_DCR_SELECT_IN_OUT];
		s.init_n = s.dcr[`EPP_DCR_INIT];
		s.hresp  = 1'b0;
	end

	always_ff @(posedge sys_clk_in) begin
		if (!resetn_in) begin
			st_q        <= '0;
			st_q.hready <= 1'b1;
			st_q.cfgb   <= `EPP_CFGB_RST;
			st_q.wsel_n <= 1'b1;
			st_q.dstb_n <= 1'b1;
			st_q.astb_n <= 1'b1;
			st_q.stb_n  <= 1'b1;
			st_q.afd_n  <= 1'b1;
			st_q.select_in_out_n <= 1'b1;
			st_q.pd_oe  <= 1'b1;
		end else begin
			st_q <= s;
		end
	end

	assign hrdata_out             = st_q.hrdata;
	assign hreadyout_out          = st_q.hready;
	assign hresp_out              = st_q.hresp;
	assign port_data_lines_out    = st_q.pd_out;
	assign port_data_lines_oe_out = st_q.pd_oe;
	assign write_select_n_out     = st_q.wsel_n;
	assign data_strobe_n_out      = st_q.dstb_n;
	assign addr_strobe_n_out      = st_q.astb_n;
	assign strobe_n_out           = st_q.stb_n;
	assign auto_feed_n_out        = st_q.afd_n;
	assign select_in_n_out        = st_q.select_in_out_n;
	assign peripheral_init_n_out  = st_q.init_n;
	assign ack_irq_out            = st_q.irq;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (!resetn_in);

	sequence seq_done_answer;
		st_q.cyc == EPP_CYC_DONE ##1 (st_q.cyc == EPP_CYC_IDLE
			&& st_q.hready);
	endsequence

	chk_wdog_abort: assert property (
		(st_q.cyc inside {EPP_CYC_WAITGO, EPP_CYC_STROBE}
		&& st_q.wdog == 10'(`EPP_TMO_CYC)) |=> st_q.tmo ##0 seq_done_answer)
		else $error("watchdog did not abort the cycle");
	chk_wdog_bound: assert property (
		st_q.wdog <= 10'(`EPP_TMO_CYC))
		else $error("watchdog count ran past its limit");
	chk_tmo_clear: assert property (
		(tmo_clr && !tmo_set) |=> !st_q.tmo)
		else $error("time-out bit not cleared by write of one");
	chk_idle_dir: assert property (
		(s.cyc == EPP_CYC_IDLE && s.mode == EPP_MODE_EPP)
		|=> st_q.pd_oe == !st_q.dcr[`EPP_DCR_DIR])
		else $error("idle epp port ignores direction bit");
	chk_read_wsel: assert property (
		(st_q.cyc == EPP_CYC_STROBE && !st_q.cyc_wr)
		|-> st_q.wsel_n && !(st_q.dstb_n && st_q.astb_n))
		else $error("read cycle strobe or write select wrong");
	chk_v19_done: assert property (
		(st_q.cyc == EPP_CYC_STROBE && st_q.seen_low && wait_s
		&& st_q.wdog < 10'(`EPP_TMO_CYC)) |=> seq_done_answer)
		else $error("cycle did not end on wait release");
	chk_v19_hold: assert property (
		(st_q.cyc == EPP_CYC_WAITGO && wait_s
		&& st_q.wdog < 10'(`EPP_TMO_CYC))
		|=> st_q.cyc == EPP_CYC_WAITGO && st_q.dstb_n && st_q.astb_n)
		else $error("cycle started while wait was high");
	chk_v17_end: assert property (
		(st_q.cyc == EPP_CYC_STROBE && !st_q.seen_low
		&& st_q.wdog < 10'(`EPP_TMO_CYC)) |=> st_q.cyc == EPP_CYC_STROBE)
		else $error("cycle ended without a wait low-to-high");
	chk_fifo_std: assert property (
		st_q.mode == EPP_MODE_STD |=> f_empty)
		else $error("fifo not reset in standard mode");
	chk_dsr_bits: assert property (
		(st_q.dp && !st_q.hready && !st_q.dp_wr
		&& st_q.dp_idx == `EPP_IDX_DSR)
		|=> st_q.hrdata[2:1] == 2'b11 && st_q.hrdata[7] == !$past(busy_s))
		else $error("status read value wrong");
	chk_dcr_top: assert property (
		(st_q.dp && !st_q.hready && !st_q.dp_wr
		&& st_q.dp_idx == `EPP_IDX_DCR) |=> st_q.hrdata[7:6] == 2'b11)
		else $error("control bits 7 and 6 not read as one");
	chk_dir_forced: assert property (
		(s.cyc == EPP_CYC_IDLE
		&& (s.mode == EPP_MODE_STD || s.mode == EPP_MODE_FIFO))
		|=> st_q.pd_oe)
		else $error("port not driving in mode 000 or 010");
	chk_ack_irq: assert property (
		(ack_s && !st_q.ack_d && st_q.dcr[`EPP_DCR_IRQEN])
		|=> st_q.irq ##1 !st_q.irq)
		else $error("ack edge gave no single interrupt pulse");
	chk_ctl_pins: assert property (
		st_q.select_in_out_n == !st_q.dcr[`EPP_DCR_SELECT_IN_OUT]
		&& st_q.afd_n == !st_q.dcr[`EPP_DCR_AFD]
		&& st_q.init_n == st_q.dcr[`EPP_DCR_INIT])
		else $error("control pins do not follow control register");
	chk_ecp_tag: assert property (
		(st_q.dp && !st_q.hready && st_q.dp_wr && !acc_epp
		&& st_q.dp_idx == `EPP_IDX_DATA && st_q.mode == EPP_MODE_ECP)
		|-> f_push && f_pdata[8])
		else $error("address byte not tagged into fifo");
endmodule : epp_port

// ==== hdl/epp_sync2.sv ====
`timescale 1ns/1ps
module epp_sync2 #(
	parameter int W = 1
) (
	input  wire logic         sys_clk_in, // system clock
	input  wire logic         resetn_in,  // sync reset, active low
	input  wire logic [W-1:0] async_in,   // pin levels
	output logic      [W-1:0] sync_out    // levels after two flops
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} epp_sync_st_t;

	epp_sync_st_t st_q;
	epp_sync_st_t st_d;

	always_comb begin
		st_d    = st_q;
		st_d.s1 = async_in;
		st_d.s2 = st_q.s1;
	end

	always_ff @(posedge sys_clk_in) begin
		if (!resetn_in) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign sync_out = st_q.s2;
endmodule : epp_sync2
